// File: mrd_params.svh
`ifndef MRD_PARAMS_SVH
`define MRD_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MRD_OFF_INSTR 12'h000
`define MRD_OFF_ACC 12'h004
`define MRD_OFF_STATUS 12'h008
`define MRD_OFF_PC 12'h00c
`define MRD_OFF_LATCH 12'h010
`define MRD_OFF_CTRL 12'h014
`define MRD_OFF_CYCLES 12'h018
`define MRD_OFF_STACK 12'h01c
`define MRD_FILE_REGION 3'h1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MRD_ST_C 0
`define MRD_ST_DC 1
`define MRD_ST_Z 2
`define MRD_ST_PD 3
`define MRD_ST_TO 4
`define MRD_ST_FLUSH 5
`define MRD_ST_GIE 6
`define MRD_CTRL_PSA 0
`define MRD_LATCH_PAGE 4:3

// ----------------------------------------------------------------
// Reset values and defaults
// ----------------------------------------------------------------
`define MRD_RST_ACC 8'h00
`define MRD_RST_STATUS 8'h18
`define MRD_RST_PC 13'h0000
`define MRD_RST_LATCH 8'h00
`define MRD_RST_CTRL 8'h00
`define MRD_PORT_ADDR 7'h06
`define MRD_TIMER_ADDR 7'h01
`define MRD_STACK_DEPTH 8

// ----------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------
`define MRD_GRP_BYTE 2'h0
`define MRD_GRP_BIT 2'h1
`define MRD_GRP_CTRL 2'h2
`define MRD_GRP_LIT 2'h3
`define MRD_B_MISC 4'h0
`define MRD_B_CLR 4'h1
`define MRD_B_SUB 4'h2
`define MRD_B_DEC 4'h3
`define MRD_B_IOR 4'h4
`define MRD_B_AND 4'h5
`define MRD_B_XOR 4'h6
`define MRD_B_ADD 4'h7
`define MRD_B_MOV 4'h8
`define MRD_B_COM 4'h9
`define MRD_B_INC 4'ha
`define MRD_B_DECSZ 4'hb
`define MRD_B_RRC 4'hc
`define MRD_B_RLC 4'hd
`define MRD_B_SWAP 4'he
`define MRD_B_INCSZ 4'hf
`define MRD_M_RET 8'h08
`define MRD_M_IRET 8'h09
`define MRD_M_SLEEP 8'h63
`define MRD_M_WDT 8'h64
`define MRD_BIT_CLR 2'h0
`define MRD_BIT_SET 2'h1
`define MRD_BIT_TSTC 2'h2
`define MRD_BIT_TSTS 2'h3
`define MRD_L_LOAD 2'h0
`define MRD_L_RETURN_WITH_LITERAL 2'h1
`define MRD_L_IOR 4'h8
`define MRD_L_AND 4'h9
`define MRD_L_XOR 4'ha
`define MRD_L_SUB 3'h6
`define MRD_L_ADD 3'h7

`endif

// File: mrd_pkg.sv
package mrd_pkg;

   typedef enum logic [3:0] {
      alu_pass_a, alu_pass_b, alu_add, alu_sub, alu_and, alu_or,
      alu_xor, alu_com, alu_inc, alu_dec, alu_rlc, alu_rrc,
      alu_swap, alu_clr
   } mrd_alu_op_t;

   typedef struct packed {
      logic zero;
      logic digit_carry;
      logic carry;
   } mrd_flags_t;

   typedef struct packed {
      mrd_alu_op_t op;
      logic use_k;
      logic wr_w;
      logic wr_f;
      logic upd_cdc;
      logic upd_c;
      logic upd_z;
      logic skip_zero;
      logic bit_clr;
      logic bit_set;
      logic test_clr;
      logic test_set;
      logic call;
      logic jump;
      logic ret;
      logic iret;
      logic wdt;
      logic sleep;
   } mrd_ctl_t;

endpackage

// File: mrd_alu.sv
`timescale 1ns/1ps
module mrd_alu
(
   input wire mrd_pkg::mrd_alu_op_t op,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic carry_in,
   output logic [7:0] result,
   output mrd_pkg::mrd_flags_t flags
);
   import mrd_pkg::*;

   // Subtraction is a plus not-b plus one, so carry means no borrow.
   logic sub;
   logic [7:0] b_in;
   logic [8:0] sum;
   logic [4:0] half;

   assign sub = (op == alu_sub);
   assign b_in = sub ? ~b : b;
   assign sum = {1'b0, a} + {1'b0, b_in} + {8'h00, sub};
   assign half = {1'b0, a[3:0]} + {1'b0, b_in[3:0]} + {4'h0, sub};

   always_comb
   begin
      result = a;
      flags.carry = carry_in;
      flags.digit_carry = half[4];
      unique case (op)
         alu_pass_a: result = a;
         alu_pass_b: result = b;
         alu_add, alu_sub:
         begin
            result = sum[7:0];
            flags.carry = sum[8];
         end
         alu_and: result = a & b;
         alu_or: result = a | b;
         alu_xor: result = a ^ b;
         alu_com: result = ~a;
         alu_inc: result = a + 8'h01;
         alu_dec: result = a - 8'h01;
         alu_rlc:
         begin
            result = {a[6:0], carry_in};
            flags.carry = a[7];
         end
         alu_rrc:
         begin
            result = {carry_in, a[7:1]};
            flags.carry = a[0];
         end
         alu_swap: result = {a[3:0], a[7:4]};
         alu_clr: result = 8'h00;
         default: result = a;
      endcase
      flags.zero = (result == 8'h00);
   end

endmodule // mrd_alu

// File: mrd_stack.sv
`timescale 1ns/1ps
module mrd_stack
#(
   parameter int DEPTH = 8,
   parameter int WIDTH = 13
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] push_data,
   output logic [WIDTH-1:0] top
);
   localparam int PW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << PW) != DEPTH)
   begin : g_bad_depth
      $error("Stack depth must be a power of two, at least two.");
   end

   // The pointer wraps: overflow overwrites the oldest entry.
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] ptr_q;

   assign top = mem_q[ptr_q - PW'(1)];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ptr_q <= '0;
      else if (push)
         ptr_q <= ptr_q + PW'(1);
      else if (pop)
         ptr_q <= ptr_q - PW'(1);
   end

   always_ff @(posedge pclk)
   begin
      if (push)
         mem_q[ptr_q] <= push_data;
   end

endmodule // mrd_stack

// File: mrd_decoder.sv
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "mrd_params.svh"

// Behaviour
// [RULE_01] Add and subtract with file compute result, update carry, digit carry, zero.
// [RULE_02] AND of accumulator with file updates only zero.
// [RULE_03] OR, XOR, complement and move of a file update only zero.
// [RULE_04] Increment, decrement update zero; skip variants skip on zero, no flags.
// [RULE_05] Rotates go through carry, changing only carry; swap changes no flag.
// [RULE_06] Destination bit zero writes accumulator, one writes file; address 0 to 127.
// [RULE_07] Clearing file or accumulator loads zero and sets zero flag.
// [RULE_08] Bit tests skip next instruction on clear or set bit; no flags.
// [RULE_09] Bit clear and bit set force one file bit, status unchanged.
// [RULE_10] Add literal sums accumulator and constant, updating carry, digit carry, zero.
// [RULE_11] Literal AND, OR, XOR write accumulator and update only zero.
// [RULE_12] Subtract from literal stores constant minus accumulator, updating three flags.
// [RULE_13] Load literal sets accumulator flag-free; return with literal also pops.
// [RULE_14] Taken branches and successful skips take two cycles, second a no-op.
// [RULE_15] Call pushes next address, loads eleven bits, upper bits from latch.
// [RULE_16] Watchdog clear and standby take one cycle and set timeout, powerdown; the code clears powerdown on standby.
// [RULE_17] Reading a port register for modification samples the pins.
// [RULE_18] Writing the timer count clears the prescaler when it is assigned.
// [RULE_19] Store accumulator to file changes no flag; no-op does nothing.
module mrd_decoder
#(
   parameter logic [6:0] PORT_ADDR = `MRD_PORT_ADDR,
   parameter logic [6:0] TIMER_ADDR = `MRD_TIMER_ADDR,
   parameter int STACK_DEPTH = `MRD_STACK_DEPTH
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] port_pins,
   output logic [7:0] port_latch,
   output logic prescaler_clear,
   output logic watchdog_clear,
   output logic standby_enter
);
   import mrd_pkg::*;

   if (PORT_ADDR == TIMER_ADDR)
   begin : g_bad_addr
      $error("Port and timer cannot share one file address.");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0] file_q [128];
   logic [7:0] acc_q;
   logic [7:0] status_q;
   logic [12:0] pc_q;
   logic [7:0] latch_q;
   logic [7:0] ctrl_q;
   logic [31:0] cycles_q;
   logic [13:0] instr_q;
   logic [7:0] pin_meta_q;
   logic [7:0] pin_sync_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [7:0] port_latch_q;
   logic presc_q;
   logic wdt_q;
   logic sleep_q;

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign port_latch = port_latch_q;
   assign prescaler_clear = presc_q;
   assign watchdog_clear = wdt_q;
   assign standby_enter = sleep_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   function automatic logic reg_hit(input logic [11:0] a);
      reg_hit = (a[1:0] == 2'h0) &&
         ((a[11:9] == `MRD_FILE_REGION) || (a <= `MRD_OFF_STACK));
   endfunction

   logic setup_ph;
   logic wr_acc;
   logic hit_file;
   logic exec;
   logic run;

   assign setup_ph = psel & penable & ~pready_q;
   assign wr_acc = psel & penable & pready_q & pwrite;
   assign hit_file = (paddr[11:9] == `MRD_FILE_REGION) &
      (paddr[1:0] == 2'h0);
   assign exec = wr_acc & (paddr == `MRD_OFF_INSTR);
   // A word arriving while a flush is pending is discarded as a no-op.
   assign run = exec & ~status_q[`MRD_ST_FLUSH]; // [RULE_14]

   // ----------------------------------------------------------------
   // Instruction decode
   // ----------------------------------------------------------------
   logic [13:0] ins;
   logic [6:0] faddr;
   logic [2:0] bsel;
   mrd_ctl_t ctl;

   assign ins = pwdata[13:0];
   assign faddr = ins[6:0]; // [RULE_06]
   assign bsel = ins[9:7];

   always_comb
   begin
      ctl = '0;
      ctl.op = alu_pass_a;
      unique case (ins[13:12])
         `MRD_GRP_BYTE:
         begin
            ctl.wr_f = ins[7]; // [RULE_06]
            ctl.wr_w = ~ins[7]; // [RULE_06]
            unique case (ins[11:8])
               `MRD_B_MISC:
               begin
                  // Store to file, or no-op and control forms.
                  ctl.wr_w = 1'b0;
                  ctl.op = alu_pass_b; // [RULE_19]
                  ctl.ret = ~ins[7] & ((ins[7:0] == `MRD_M_RET) |
                     (ins[7:0] == `MRD_M_IRET)); // [RULE_14]
                  ctl.iret = ~ins[7] & (ins[7:0] == `MRD_M_IRET);
                  ctl.wdt = ~ins[7] & (ins[7:0] == `MRD_M_WDT);
                  ctl.sleep = ~ins[7] & (ins[7:0] == `MRD_M_SLEEP);
               end
               `MRD_B_CLR:
               begin
                  ctl.op = alu_clr; // [RULE_07]
                  ctl.upd_z = 1'b1; // [RULE_07]
               end
               `MRD_B_SUB:
               begin
                  ctl.op = alu_sub; // [RULE_01]
                  ctl.upd_cdc = 1'b1; // [RULE_01]
                  ctl.upd_z = 1'b1;
               end
               `MRD_B_ADD:
               begin
                  ctl.op = alu_add; // [RULE_01]
                  ctl.upd_cdc = 1'b1; // [RULE_01]
                  ctl.upd_z = 1'b1;
               end
               `MRD_B_AND:
               begin
                  ctl.op = alu_and; // [RULE_02]
                  ctl.upd_z = 1'b1; // [RULE_02]
               end
               `MRD_B_IOR:
               begin
                  ctl.op = alu_or; // [RULE_03]
                  ctl.upd_z = 1'b1; // [RULE_03]
               end
               `MRD_B_XOR:
               begin
                  ctl.op = alu_xor; // [RULE_03]
                  ctl.upd_z = 1'b1; // [RULE_03]
               end
               `MRD_B_COM:
               begin
                  ctl.op = alu_com; // [RULE_03]
                  ctl.upd_z = 1'b1; // [RULE_03]
               end
               `MRD_B_MOV: ctl.upd_z = 1'b1; // [RULE_03]
               `MRD_B_INC:
               begin
                  ctl.op = alu_inc; // [RULE_04]
                  ctl.upd_z = 1'b1; // [RULE_04]
               end
               `MRD_B_DEC:
               begin
                  ctl.op = alu_dec; // [RULE_04]
                  ctl.upd_z = 1'b1; // [RULE_04]
               end
               `MRD_B_INCSZ:
               begin
                  ctl.op = alu_inc; // [RULE_04]
                  ctl.skip_zero = 1'b1; // [RULE_04]
               end
               `MRD_B_DECSZ:
               begin
                  ctl.op = alu_dec; // [RULE_04]
                  ctl.skip_zero = 1'b1; // [RULE_04]
               end
               `MRD_B_RLC:
               begin
                  ctl.op = alu_rlc; // [RULE_05]
                  ctl.upd_c = 1'b1; // [RULE_05]
               end
               `MRD_B_RRC:
               begin
                  ctl.op = alu_rrc; // [RULE_05]
                  ctl.upd_c = 1'b1; // [RULE_05]
               end
               `MRD_B_SWAP: ctl.op = alu_swap; // [RULE_05]
            endcase
         end
         `MRD_GRP_BIT:
         begin
            ctl.bit_clr = (ins[11:10] == `MRD_BIT_CLR); // [RULE_09]
            ctl.bit_set = (ins[11:10] == `MRD_BIT_SET); // [RULE_09]
            ctl.test_clr = (ins[11:10] == `MRD_BIT_TSTC); // [RULE_08]
            ctl.test_set = (ins[11:10] == `MRD_BIT_TSTS); // [RULE_08]
            ctl.wr_f = ctl.bit_clr | ctl.bit_set;
            ctl.op = ctl.bit_clr ? alu_and : alu_or; // [RULE_09]
         end
         `MRD_GRP_CTRL:
         begin
            ctl.call = ~ins[11]; // [RULE_15]
            ctl.jump = ins[11]; // [RULE_14]
         end
         `MRD_GRP_LIT:
         begin
            ctl.use_k = 1'b1;
            ctl.wr_w = 1'b1;
            if (ins[11:10] == `MRD_L_LOAD)
               ctl.op = alu_pass_a; // [RULE_13]
            else if (ins[11:10] == `MRD_L_RETURN_WITH_LITERAL)
               ctl.ret = 1'b1; // [RULE_13]
            else if (ins[11:9] == `MRD_L_ADD)
            begin
               ctl.op = alu_add; // [RULE_10]
               ctl.upd_cdc = 1'b1; // [RULE_10]
               ctl.upd_z = 1'b1; // [RULE_10]
            end
            else if (ins[11:9] == `MRD_L_SUB)
            begin
               ctl.op = alu_sub; // [RULE_12]
               ctl.upd_cdc = 1'b1; // [RULE_12]
               ctl.upd_z = 1'b1; // [RULE_12]
            end
            else if (ins[11:8] == `MRD_L_IOR || ins[11:8] == `MRD_L_AND
               || ins[11:8] == `MRD_L_XOR)
            begin
               ctl.op = (ins[11:8] == `MRD_L_IOR) ? alu_or : // [RULE_11]
                  (ins[11:8] == `MRD_L_AND) ? alu_and : alu_xor;
               ctl.upd_z = 1'b1; // [RULE_11]
            end
            else
               ctl.wr_w = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Datapath
   // ----------------------------------------------------------------
   logic [7:0] fval;
   logic [7:0] mask;
   logic [7:0] a_opd;
   logic [7:0] b_opd;
   logic [7:0] result;
   mrd_flags_t flags;
   logic skip;
   logic branch;
   logic [12:0] pc_next;
   logic [12:0] stack_top;
   logic file_we;
   logic [6:0] file_wa;
   logic [7:0] file_wd;

   // Port reads see the pins, so a write-back follows external drive.
   assign fval = (faddr == PORT_ADDR) ? pin_sync_q : file_q[faddr]; // [RULE_17]
   assign mask = 8'h01 << bsel;
   assign a_opd = ctl.use_k ? ins[7:0] : fval;
   assign b_opd = ctl.bit_clr ? ~mask : ctl.bit_set ? mask : acc_q;

   mrd_alu u_alu
   (
      .op(ctl.op),
      .a(a_opd),
      .b(b_opd),
      .carry_in(status_q[`MRD_ST_C]),
      .result(result),
      .flags(flags)
   );

   assign skip = (ctl.skip_zero & flags.zero) | // [RULE_04]
      (ctl.test_clr & ~fval[bsel]) | (ctl.test_set & fval[bsel]); // [RULE_08]
   assign branch = ctl.call | ctl.jump | ctl.ret; // [RULE_14]

   always_comb
   begin
      if (ctl.call | ctl.jump)
         pc_next = {latch_q[`MRD_LATCH_PAGE], ins[10:0]}; // [RULE_15]
      else if (ctl.ret)
         pc_next = stack_top; // [RULE_13]
      else if (skip)
         pc_next = pc_q + 13'h0002; // [RULE_14]
      else
         pc_next = pc_q + 13'h0001;
   end

   mrd_stack #(.DEPTH(STACK_DEPTH), .WIDTH(13)) u_stack
   (
      .pclk(pclk),
      .presetn(presetn),
      .push(run & ctl.call), // [RULE_15]
      .pop(run & ctl.ret), // [RULE_13]
      .push_data(pc_q + 13'h0001), // [RULE_15]
      .top(stack_top)
   );

   always_comb
   begin
      file_we = 1'b0;
      file_wa = paddr[8:2];
      file_wd = pwdata[7:0];
      if (wr_acc & hit_file)
         file_we = 1'b1;
      else if (run & ctl.wr_f)
      begin
         file_we = 1'b1; // [RULE_06]
         file_wa = faddr;
         file_wd = result;
      end
   end

   always_ff @(posedge pclk)
   begin
      if (file_we)
         file_q[file_wa] <= file_wd;
   end

   // ----------------------------------------------------------------
   // Architectural registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         acc_q <= `MRD_RST_ACC;
      else if (run & ctl.wr_w)
         acc_q <= result; // [RULE_06]
      else if (wr_acc & (paddr == `MRD_OFF_ACC))
         acc_q <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_q <= `MRD_RST_STATUS;
      else if (exec)
      begin
         status_q[`MRD_ST_FLUSH] <= run & (skip | branch); // [RULE_14]
         if (run & (ctl.upd_cdc | ctl.upd_c))
            status_q[`MRD_ST_C] <= flags.carry; // [RULE_05]
         if (run & ctl.upd_cdc)
            status_q[`MRD_ST_DC] <= flags.digit_carry; // [RULE_01]
         if (run & ctl.upd_z)
            status_q[`MRD_ST_Z] <= flags.zero; // [RULE_07]
         if (run & (ctl.wdt | ctl.sleep))
         begin
            status_q[`MRD_ST_TO] <= 1'b1; // [RULE_16]
            status_q[`MRD_ST_PD] <= ctl.wdt; // [RULE_16]
         end
         if (run & ctl.iret)
            status_q[`MRD_ST_GIE] <= 1'b1;
      end
      else if (wr_acc & (paddr == `MRD_OFF_STATUS))
      begin
         status_q[`MRD_ST_C] <= pwdata[`MRD_ST_C];
         status_q[`MRD_ST_DC] <= pwdata[`MRD_ST_DC];
         status_q[`MRD_ST_Z] <= pwdata[`MRD_ST_Z];
         status_q[`MRD_ST_GIE] <= pwdata[`MRD_ST_GIE];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pc_q <= `MRD_RST_PC;
         cycles_q <= 32'h0000_0000;
         instr_q <= 14'h0000;
      end
      else if (exec)
      begin
         // Every word costs one cycle; a discarded one is the second.
         cycles_q <= cycles_q + 32'h0000_0001; // [RULE_14]
         instr_q <= ins;
         if (run)
            pc_q <= pc_next;
      end
      else if (wr_acc & (paddr == `MRD_OFF_PC))
         pc_q <= pwdata[12:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         latch_q <= `MRD_RST_LATCH;
         ctrl_q <= `MRD_RST_CTRL;
      end
      else if (wr_acc & (paddr == `MRD_OFF_LATCH))
         latch_q <= pwdata[7:0];
      else if (wr_acc & (paddr == `MRD_OFF_CTRL))
         ctrl_q <= pwdata[7:0];
   end

   // ----------------------------------------------------------------
   // Pins and side effects
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_meta_q <= 8'h00;
         pin_sync_q <= 8'h00;
      end
      else
      begin
         pin_meta_q <= port_pins;
         pin_sync_q <= pin_meta_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         port_latch_q <= 8'h00;
      else if (file_we & (file_wa == PORT_ADDR))
         port_latch_q <= file_wd;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         presc_q <= 1'b0;
         wdt_q <= 1'b0;
         sleep_q <= 1'b0;
      end
      else
      begin
         presc_q <= run & ctl.wr_f & (faddr == TIMER_ADDR) &
            ctrl_q[`MRD_CTRL_PSA]; // [RULE_18]
         wdt_q <= run & ctl.wdt; // [RULE_16]
         sleep_q <= run & ctl.sleep; // [RULE_16]
      end
   end

   // ----------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------
   // One wait state keeps every answer registered.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= setup_ph;
         pslverr_q <= setup_ph & ~reg_hit(paddr);
         prdata_q <= 32'h0000_0000;
         if (setup_ph & ~pwrite)
         begin
            if (hit_file)
               prdata_q <= {24'h00_0000, file_q[paddr[8:2]]};
            else
               unique case (paddr)
                  `MRD_OFF_INSTR: prdata_q <= {18'h0_0000, instr_q};
                  `MRD_OFF_ACC: prdata_q <= {24'h00_0000, acc_q};
                  `MRD_OFF_STATUS: prdata_q <= {24'h00_0000, status_q};
                  `MRD_OFF_PC: prdata_q <= {19'h0_0000, pc_q};
                  `MRD_OFF_LATCH: prdata_q <= {24'h00_0000, latch_q};
                  `MRD_OFF_CTRL: prdata_q <= {24'h00_0000, ctrl_q};
                  `MRD_OFF_CYCLES: prdata_q <= cycles_q;
                  `MRD_OFF_STACK: prdata_q <= {19'h0_0000, stack_top};
                  default: prdata_q <= 32'h0000_0000;
               endcase
         end
      end
   end

endmodule // mrd_decoder

// File: mrd_decoder_props.sv
`timescale 1ns/1ps
module mrd_decoder_props
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic prescaler_clear,
   input wire logic watchdog_clear,
   input wire logic standby_enter
);
   logic exe_q;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Pulses are registered, so their cause lies one edge back.
   always_ff @(posedge pclk)
      exe_q <= psel && penable && pready && pwrite && paddr == 12'h000;
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   AST_ONE_WAIT: assert property (s_wait |=> pready) else $error("no ready");
   AST_PULSE: assert property (pready |=> !pready) else $error("long ready");
   AST_SETUP: assert property (psel && !penable |-> !pready)
      else $error("early ready");
   AST_WDT: assert property (watchdog_clear |-> exe_q)
      else $error("stray watchdog pulse");
   AST_STB: assert property (standby_enter |-> exe_q)
      else $error("stray standby pulse");
   AST_WDT1: assert property (watchdog_clear |=> !watchdog_clear)
      else $error("long watchdog pulse");
   AST_BOTH: assert property (!(watchdog_clear && standby_enter))
      else $error("both pulses");
   AST_PSC: assert property (prescaler_clear |-> exe_q)
      else $error("stray prescaler clear");
endmodule // mrd_decoder_props
bind mrd_decoder mrd_decoder_props mrd_decoder_props_inst (.*);

// File: mrd_pin_model.sv
`timescale 1ns/1ps
module mrd_pin_model
(
   input wire logic pclk,
   input wire logic [7:0] lvl,
   output logic [7:0] port_pins = 8'h00
);
   always @(posedge pclk)
      port_pins <= lvl;
endmodule // mrd_pin_model

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, prescaler_clear;
   logic watchdog_clear, standby_enter;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h00012b60;
   logic [7:0] port_pins, port_latch, lvl = 8'h00;
   logic [32:0] expq[$];
   int num_errors = 0, cmp_count = 0;
   logic [32:0] psc_n = '0, wdt_n = '0, stb_n = '0;
   always #4 pclk = ~pclk;
   mrd_decoder mrd_decoder_inst (.*);
   mrd_pin_model mrd_pin_model_inst (.*);
   initial #100000 conclude(1);
   task automatic conclude(int extra);
      num_errors += extra + expq.size();
      $display("errors %0d of %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(logic [32:0] got, logic [32:0] exp);
      cmp_count++;
      num_errors += int'(got !== exp);
      if (got !== exp)
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
   endtask
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      {psel, penable} <= 2'b00;
   endtask
   // Every check but the closing ones on port_latch and the pulse counts rides on a read; writes show only when read back.
   task automatic rd(logic [11:0] a, logic [32:0] e);
      expq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic ex(logic [13:0] i);
      apb(1'b1, 12'h000, {18'h0, i});
   endtask
   task automatic st(logic [7:0] v, logic z, logic dc, logic c);
      rd(12'h004, {25'h0, v});
      rd(12'h008, {30'h3, z, dc, c});
   endtask
   function automatic logic [7:0] rand8();
      rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      return rnd[7:0];
   endfunction
   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk({pslverr, prdata}, expq.pop_front());
   always @(posedge pclk)
      if (presetn)
      begin
         psc_n <= psc_n + {32'h0, prescaler_clear};
         wdt_n <= wdt_n + {32'h0, watchdog_clear};
         stb_n <= stb_n + {32'h0, standby_enter};
      end
   initial
   begin
      logic [7:0] a, b, t;
      logic [8:0] s, u;
      logic h;
      lvl = rand8();
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h008, 33'h18);
      rd(12'h100, 33'h100000000);
      ex(14'h0806);
      rd(12'h004, {25'h0, lvl});
      a = rand8();
      b = rand8();
      s = a + b;
      ex({6'h30, a});
      ex({6'h3e, b});
      st(s[7:0], s[7:0] == 8'h00, s[4] ^ a[4] ^ b[4], s[8]);
      t = s[7:0];
      apb(1'b1, 12'h284, {24'h0, b});
      ex(14'h07a1);
      u = b + t;
      h = u[4] ^ b[4] ^ t[4];
      rd(12'h284, {25'h0, u[7:0]});
      ex(14'h01a1);
      rd(12'h284, 33'h0);
      st(t, 1'b1, h, u[8]);
      ex(14'h0063);
      rd(12'h008, {30'h2, 1'b1, h, u[8]});
      ex(14'h0064);
      apb(1'b1, 12'h00c, 32'h0);
      ex(14'h19a1);
      ex({6'h30, b});
      st(t, 1'b1, h, u[8]);
      rd(12'h00c, 33'h2);
      apb(1'b1, 12'h014, 32'h1);
      ex(14'h0081);
      ex(14'h0086);
      ex({6'h3c, a});
      u = {1'b0, a} + {1'b0, ~t} + 9'h001;
      h = (a[3:0] >= t[3:0]);
      st(u[7:0], u[7:0] == 8'h00, h, u[8]);
      ex(14'h0d06);
      st({lvl[6:0], u[8]}, u[7:0] == 8'h00, h, lvl[7]);
      apb(1'b1, 12'h010, 32'h18);
      apb(1'b1, 12'h00c, 32'h5);
      ex(14'h2123);
      rd(12'h00c, 33'h1923);
      rd(12'h01c, 33'h6);
      rd(12'h018, 33'he);
      @(posedge pclk);
      chk({25'h0, port_latch}, {25'h0, t});
      chk(psc_n, 33'h1);
      chk(wdt_n, 33'h1);
      chk(stb_n, 33'h1);
      conclude(0);
   end
endmodule // testbench
